// ---- src/fcp_access.sv ----
/*
  Two-wire access logic for a nonvolatile byte array plus companion block.
  Assumes every pin is asynchronous to clock_in and that the bus clock is
  much slower than clock_in; the reset pin and data pin are open drain.
*/
// What this block does
// - Answer only when select pins match the address select bits.
// - Unconnected select inputs read low through internal pull-downs.
// - Launch output data on clock fall, sample input on clock rise.
// - Event input one, and event input two outside cascade mode, advance their counters on the chosen edge.
// - In calibration mode the shared output is a 512 Hz square wave.
// - Outside calibration mode the shared output follows power-fail.
// - Reset line is open drain: drives low only, otherwise floats high.
// - An external low on the reset line requests a manual reset.
// - Memory and companion answer as two targets with distinct IDs.
// - Companion accesses leave the memory address pointer untouched.
// - Companion holds a bank of 25 byte-wide registers.
// - Counters keep running on backup supply.
// - Two-byte memory address selects a byte in 8192 or 32768 bytes.
// - Memory writes complete at bus speed with no busy interval.
// - Two protect bits guard none, lowest quarter, lowest half, or all.
// - Bytes to protected addresses are dropped and not acknowledged.
// - While reset is asserted all bus activity is ignored.
`timescale 1ns/1ps
`default_nettype none
module fcp_access #(
  parameter bit DENSITY_LARGE = 1'b1,
  parameter int RST_HOLD = fcp_pkg::RST_HOLD_CYC
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] device_select_pins_in,
  input wire logic event_input_one_in,
  input wire logic event_input_two_in,
  input wire logic powerfail_sense_input_in,
  input wire logic osc_32k_in,
  input wire logic supply_low_in,
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe_out,
  output logic cal_powerfail_output_out
);
  import fcp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  fcp_pins_t raw, s1_r, s2_r, s3_r, pin_r, pin_nxt, prev_r;

  // Select pins are pulled down on the pad, so a floating pin arrives low
  assign raw = '{scl: scl_in, sda: sda_in, dsel: device_select_pins_in,
                 ev1: event_input_one_in, ev2: event_input_two_in,
                 powerfail_sense_input: powerfail_sense_input_in, osc: osc_32k_in,
                 rst_pin: reset_line_in, supply_low: supply_low_in};

  // A change counts once the second and third stages agree
  always_comb begin
    pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // Idle levels, so no false edge or manual reset follows reset
      s1_r <= PINS_IDLE;
      s2_r <= PINS_IDLE;
      s3_r <= PINS_IDLE;
      pin_r <= PINS_IDLE;
      prev_r <= PINS_IDLE;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
      prev_r <= pin_r;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = pin_r.scl && !prev_r.scl;
  assign scl_fall = !pin_r.scl && prev_r.scl;
  assign start_det = pin_r.scl && prev_r.scl && !pin_r.sda && prev_r.sda;
  assign stop_det = pin_r.scl && prev_r.scl && pin_r.sda && !prev_r.sda;

  //////////////////////////////////////////////////////////////////////////
  // Reset line: supply supervisor and manual request

  logic [31:0] hold_r, hold_nxt;
  logic [3:0] settle_r, settle_nxt;
  logic rst_drv_r, rst_drv_nxt, manual_req;

  // Ignore our own low level until the pin has had time to float back up
  assign manual_req = !pin_r.rst_pin && !rst_drv_r && (settle_r == '0);

  always_comb begin
    hold_nxt = hold_r;
    settle_nxt = settle_r;
    if (pin_r.supply_low || manual_req) begin
      hold_nxt = 32'(RST_HOLD);
    end else if (hold_r != '0) begin
      hold_nxt = hold_r - 32'h1;
    end
    rst_drv_nxt = pin_r.supply_low || manual_req || (hold_nxt != '0);
    if (rst_drv_r) begin
      settle_nxt = RST_SETTLE_CYC;
    end else if (settle_r != '0) begin
      settle_nxt = settle_r - 4'h1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_r <= '0;
      settle_r <= '0;
      rst_drv_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      settle_r <= settle_nxt;
      rst_drv_r <= rst_drv_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memory path: write FIFO and array

  fcp_wr_t push_data, drain_data;
  logic push_valid, push_ready, drain_valid;
  logic [7:0] mem_rdata;

  fcp_fifo #(.WIDTH(WR_W), .DEPTH(4)) u_fifo (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_data),
    .out_valid_out(drain_valid),
    .out_ready_in(1'b1),
    .out_data_out(drain_data)
  );

  logic [14:0] mem_ptr_r, mem_ptr_nxt;

  // Every queued byte lands in the array the next cycle, far inside a bit
  fcp_mem u_mem (
    .clock_in(clock_in),
    .we_in(drain_valid),
    .waddr_in(drain_data.addr),
    .wdata_in(drain_data.data),
    .raddr_in(mem_ptr_r),
    .rdata_out(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Companion register bank and event counters

  logic [7:0] creg_r [0:24];
  logic [7:0] creg_nxt [0:24];
  logic creg_we;
  logic [4:0] comp_ptr_r, comp_ptr_nxt;
  logic [7:0] creg_wdata;
  logic [15:0] event_input_one, event_input_two, event_input_one_nxt, event_input_two_nxt;
  logic edge1, edge2, inc1, inc2, cascade;

  assign cascade = creg_r[REG_EVCTL][CASC_BIT];
  assign event_input_one = {creg_r[REG_EVENT_INPUT_ONE_HI], creg_r[REG_EVENT_INPUT_ONE_LO]};
  assign event_input_two = {creg_r[REG_EVENT_INPUT_TWO_HI], creg_r[REG_EVENT_INPUT_TWO_LO]};
  // Polarity bit set counts rising edges, clear counts falling edges
  assign edge1 = creg_r[REG_EVCTL][POL1_BIT] ? (pin_r.ev1 && !prev_r.ev1)
                                             : (!pin_r.ev1 && prev_r.ev1);
  assign edge2 = creg_r[REG_EVCTL][POL2_BIT] ? (pin_r.ev2 && !prev_r.ev2)
                                             : (!pin_r.ev2 && prev_r.ev2);
  // Counts are blocked during a register write; the clock domain here is
  // assumed to stay on backup power along with the counters
  assign inc1 = edge1 && !creg_we;
  assign inc2 = (cascade ? (inc1 && event_input_one == 16'hffff) : edge2) && !creg_we;
  assign event_input_one_nxt = event_input_one + 16'(inc1);
  assign event_input_two_nxt = event_input_two + 16'(inc2);

  always_comb begin
    for (int i = 0; i < 25; i++) begin
      creg_nxt[i] = creg_r[i];
    end
    creg_nxt[REG_EVENT_INPUT_ONE_LO] = event_input_one_nxt[7:0];
    creg_nxt[REG_EVENT_INPUT_ONE_HI] = event_input_one_nxt[15:8];
    creg_nxt[REG_EVENT_INPUT_TWO_LO] = event_input_two_nxt[7:0];
    creg_nxt[REG_EVENT_INPUT_TWO_HI] = event_input_two_nxt[15:8];
    if (creg_we) begin
      creg_nxt[comp_ptr_r] = creg_wdata;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 25; i++) begin
        creg_r[i] <= REG_RESET_VAL;
      end
    end else begin
      for (int i = 0; i < 25; i++) begin
        creg_r[i] <= creg_nxt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Calibration / power-fail output

  logic [5:0] cal_cnt_r, cal_cnt_nxt;
  logic cal_sq_r, cal_sq_nxt, cal_out_r, cal_out_nxt, osc_rise;

  assign osc_rise = pin_r.osc && !prev_r.osc;

  always_comb begin
    cal_cnt_nxt = cal_cnt_r;
    cal_sq_nxt = cal_sq_r;
    if (osc_rise) begin
      if (cal_cnt_r == CAL_HALF_EDGES - 6'h1) begin
        cal_cnt_nxt = '0;
        cal_sq_nxt = !cal_sq_r;
      end else begin
        cal_cnt_nxt = cal_cnt_r + 6'h1;
      end
    end
    cal_out_nxt = creg_r[REG_CAL][CAL_BIT] ? cal_sq_r : pin_r.powerfail_sense_input;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cal_cnt_r <= '0;
      cal_sq_r <= 1'b0;
      cal_out_r <= 1'b0;
    end else begin
      cal_cnt_r <= cal_cnt_nxt;
      cal_sq_r <= cal_sq_nxt;
      cal_out_r <= cal_out_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus target state machine

  fcp_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt;
  logic [1:0] byte_idx_r, byte_idx_nxt;
  logic is_comp_r, is_comp_nxt, rd_r, rd_nxt, oe_r, oe_nxt;
  logic [6:0] addr_hi_r, addr_hi_nxt;
  logic [14:0] mem_top, wp_limit;
  logic [1:0] wp;
  logic prot_hit, mem_sel, comp_sel;

  assign mem_top = DENSITY_LARGE ? MEM_TOP_LARGE : MEM_TOP_SMALL;
  assign wp = creg_r[REG_PROT][WP_LO_BIT+1:WP_LO_BIT];
  assign wp_limit = (wp == 2'b01) ? (mem_top >> 2) : (mem_top >> 1);
  assign prot_hit = (wp == 2'b11)
                    || (wp != 2'b00 && mem_ptr_r <= wp_limit);
  assign mem_sel = (shift_r[7:4] == MEM_ID)
                   && (shift_r[2:1] == pin_r.dsel);
  assign comp_sel = (shift_r[7:4] == COMP_ID)
                    && (shift_r[2:1] == pin_r.dsel);

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    byte_idx_nxt = byte_idx_r;
    is_comp_nxt = is_comp_r;
    rd_nxt = rd_r;
    oe_nxt = oe_r;
    addr_hi_nxt = addr_hi_r;
    mem_ptr_nxt = mem_ptr_r;
    comp_ptr_nxt = comp_ptr_r;
    push_valid = 1'b0;
    push_data = '{addr: mem_ptr_r, data: shift_r};
    creg_we = 1'b0;
    creg_wdata = shift_r;
    if (rst_drv_r) begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = ST_RX;
      bit_cnt_nxt = '0;
      byte_idx_nxt = '0;
      oe_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_nxt = {shift_r[6:0], pin_r.sda};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            state_nxt = ST_RXACK;
            oe_nxt = 1'b1;
            if (byte_idx_nxt != 2'h3) begin
              byte_idx_nxt = byte_idx_r + 2'h1;
            end
            if (byte_idx_r == 2'h0) begin
              is_comp_nxt = comp_sel;
              rd_nxt = shift_r[0];
              if (!mem_sel && !comp_sel) begin
                state_nxt = ST_IDLE;
                oe_nxt = 1'b0;
              end
            end else if (is_comp_r) begin
              if (byte_idx_r == 2'h1) begin
                comp_ptr_nxt = (shift_r[4:0] < REG_COUNT) ? shift_r[4:0] : '0;
              end else begin
                creg_we = 1'b1;
                comp_ptr_nxt = (comp_ptr_r == REG_COUNT - 5'h1) ? '0
                               : comp_ptr_r + 5'h1;
              end
            end else if (byte_idx_r == 2'h1) begin
              addr_hi_nxt = shift_r[6:0];
            end else if (byte_idx_r == 2'h2) begin
              mem_ptr_nxt = {addr_hi_r, shift_r} & mem_top;
            end else begin
              if (prot_hit || !push_ready) begin
                oe_nxt = 1'b0;
              end else begin
                push_valid = 1'b1;
              end
              mem_ptr_nxt = (mem_ptr_r + 15'h1) & mem_top;
            end
          end
        end
        ST_RXACK: begin
          if (scl_fall) begin
            bit_cnt_nxt = '0;
            if (rd_r) begin
              state_nxt = ST_TX;
              tx_nxt = is_comp_r ? creg_r[comp_ptr_r] : mem_rdata;
              oe_nxt = !tx_nxt[7];
            end else begin
              state_nxt = ST_RX;
              oe_nxt = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_r == 4'h8) begin
              state_nxt = ST_TXACK;
              oe_nxt = 1'b0;
            end else begin
              oe_nxt = !tx_r[3'(4'h7 - bit_cnt_r)];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            if (pin_r.sda) begin
              state_nxt = ST_IDLE;
            end else if (is_comp_r) begin
              comp_ptr_nxt = (comp_ptr_r == REG_COUNT - 5'h1) ? '0
                             : comp_ptr_r + 5'h1;
            end else begin
              mem_ptr_nxt = (mem_ptr_r + 15'h1) & mem_top;
            end
          end else if (scl_fall) begin
            state_nxt = ST_TX;
            bit_cnt_nxt = '0;
            tx_nxt = is_comp_r ? creg_r[comp_ptr_r] : mem_rdata;
            oe_nxt = !tx_nxt[7];
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      byte_idx_r <= '0;
      is_comp_r <= 1'b0;
      rd_r <= 1'b0;
      oe_r <= 1'b0;
      addr_hi_r <= '0;
      mem_ptr_r <= '0;
      comp_ptr_r <= '0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      byte_idx_r <= byte_idx_nxt;
      is_comp_r <= is_comp_nxt;
      rd_r <= rd_nxt;
      oe_r <= oe_nxt;
      addr_hi_r <= addr_hi_nxt;
      mem_ptr_r <= mem_ptr_nxt;
      comp_ptr_r <= comp_ptr_nxt;
    end
  end

  // Open-drain pins: the data value is always low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_r;
  assign reset_line_out = 1'b0;
  assign reset_line_oe_out = rst_drv_r;
  assign cal_powerfail_output_out = cal_out_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  edge_launch_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $changed(oe_r) && !$past(rst_drv_r) && !$past(start_det)
    && !$past(stop_det) && $past(state_r) != ST_RX |-> $past(scl_fall))
    else $error("data pin changed away from a clock fall");
  sel_match_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state_r == ST_RX && scl_fall && bit_cnt_r == 4'h8 && byte_idx_r == 2'h0
    && !rst_drv_r && !start_det && !stop_det && shift_r[2:1] != pin_r.dsel
    |=> state_r == ST_IDLE && !oe_r)
    else $error("answered a mismatched select address");
  ptr_hold_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    is_comp_r && state_r != ST_IDLE && $past(is_comp_r)
    |-> $stable(mem_ptr_r))
    else $error("companion access moved memory pointer");
  prot_nack_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state_r == ST_RX && scl_fall && bit_cnt_r == 4'h8 && byte_idx_r == 2'h3
    && !is_comp_r && !rst_drv_r && !start_det && !stop_det && prot_hit
    |-> !push_valid ##1 !oe_r)
    else $error("write queued to protected address");
  write_lands_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    push_valid && push_ready |-> ##[1:5] drain_valid)
    else $error("queued write did not reach the array");
  bus_lock_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    rst_drv_r |=> state_r == ST_IDLE && !oe_r)
    else $error("bus active during reset");
  man_reset_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    manual_req |=> rst_drv_r ##1 rst_drv_r)
    else $error("manual reset not honoured");
  cnt_step_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    inc1 && !cascade |=> event_input_one == $past(event_input_one) + 16'h1)
    else $error("event counter did not advance");
  cal_follow_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !creg_r[REG_CAL][CAL_BIT] ##1 !creg_r[REG_CAL][CAL_BIT]
    |-> cal_powerfail_output_out == $past(pin_r.powerfail_sense_input))
    else $error("output not following power-fail sense");
  cal_wave_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $changed(cal_sq_r) |-> $past(osc_rise) && $past(cal_cnt_r) == 6'h1f)
    else $error("calibration wave toggled off schedule");

endmodule : fcp_access
`default_nettype wire

// ---- src/fcp_pkg.sv ----
/*
  Shared constants and types for the two-wire memory/companion access block.
  Assumes a 250 MHz system clock; every pin is sampled by that clock.
*/
`default_nettype none
package fcp_pkg;

  // Target ID nibbles (memory and companion)
  localparam logic [3:0] MEM_ID = 4'ha;
  localparam logic [3:0] COMP_ID = 4'hd;

  // Memory array
  localparam int MEM_AW = 15;
  localparam logic [14:0] MEM_TOP_LARGE = 15'h7fff;
  localparam logic [14:0] MEM_TOP_SMALL = 15'h1fff;

  // Companion register bank
  localparam logic [4:0] REG_COUNT = 5'h19;
  localparam logic [4:0] REG_CAL = 5'h00;
  localparam int CAL_BIT = 2;
  localparam logic [4:0] REG_PROT = 5'h0b;
  localparam int WP_LO_BIT = 3;
  localparam logic [4:0] REG_EVCTL = 5'h0c;
  localparam int POL1_BIT = 0;
  localparam int POL2_BIT = 1;
  localparam int CASC_BIT = 2;
  localparam logic [4:0] REG_EVENT_INPUT_ONE_LO = 5'h0d;
  localparam logic [4:0] REG_EVENT_INPUT_ONE_HI = 5'h0e;
  localparam logic [4:0] REG_EVENT_INPUT_TWO_LO = 5'h0f;
  localparam logic [4:0] REG_EVENT_INPUT_TWO_HI = 5'h10;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // Calibration square wave: 32768 Hz oscillator edges per half period
  localparam logic [5:0] CAL_HALF_EDGES = 6'h20;

  // Reset line timing
  localparam int CLK_MHZ = 250;
  localparam int RST_HOLD_MS = 100;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000 * CLK_MHZ;
  localparam logic [3:0] RST_SETTLE_CYC = 4'hf;

  // Bus state machine
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_RXACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_TXACK = 5'b10000
  } fcp_state_t;

  // Synchronised pins
  typedef struct packed {
    logic scl;
    logic sda;
    logic [1:0] dsel;
    logic ev1;
    logic ev2;
    logic powerfail_sense_input;
    logic osc;
    logic rst_pin;
    logic supply_low;
  } fcp_pins_t;

  // Idle pin levels after reset: bus lines and reset line float high
  localparam fcp_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, dsel: 2'h0,
    ev1: 1'b0, ev2: 1'b0, powerfail_sense_input: 1'b0, osc: 1'b0, rst_pin: 1'b1,
    supply_low: 1'b0};

  // Memory write carried through the FIFO
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } fcp_wr_t;

  localparam int WR_W = $bits(fcp_wr_t);

endpackage : fcp_pkg
`default_nettype wire

// ---- src/fcp_mem.sv ----
/*
  Byte array with one write port and one registered read port.
  Assumes the caller keeps addresses inside the array.
*/
`timescale 1ns/1ps
`default_nettype none
module fcp_mem (
  input wire logic clock_in,
  input wire logic we_in,
  input wire logic [14:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [14:0] raddr_in,
  output logic [7:0] rdata_out
);
  import fcp_pkg::*;

  logic [7:0] mem_r [0:(1<<MEM_AW)-1];

  // Nonvolatile array: no reset on contents
  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_r[raddr_in];
  end

endmodule : fcp_mem
`default_nettype wire

// ---- src/fcp_fifo.sv ----
/*
  Small valid/ready FIFO.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fcp_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_r [0:DEPTH-1];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_r != DEPTH[AW:0]);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = buf_r[rp_r];

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      buf_r[wp_r] <= in_data_in;
    end
  end

endmodule : fcp_fifo
`default_nettype wire

// ---- verif/fcp_master.sv ----
/*
  Two-wire bus controller model, far side of the access block.
  Assumes pull-ups on both lines; the device can only pull data low.
*/
`timescale 1ns/1ps
`default_nettype none
module fcp_master (
  input wire logic dev_pull_in,
  output logic scl_out,
  output logic sda_out
);
  logic drv_lo = 1'b0;
  // Clock stands high between frames
  logic clk_r = 1'b1;
  assign scl_out = clk_r;
  // Wired-AND data line with pull-up
  assign sda_out = !(drv_lo | dev_pull_in);
  ////////////////////////////////////////////////////////////////////////
  task automatic bit_io(input logic b, output logic r);
    drv_lo = !b;
    #40 clk_r = 1'b1;
    #80 r = sda_out;
    clk_r = 1'b0;
    #40;
  endtask : bit_io
  // Repeated start too: data released while clock low, then pulled low while clock high
  task automatic start();
    drv_lo = 1'b0;
    #40 clk_r = 1'b1;
    #80 drv_lo = 1'b1;
    #80 clk_r = 1'b0;
    #40;
  endtask : start
  task automatic stop();
    drv_lo = 1'b1;
    #40 clk_r = 1'b1;
    #80 drv_lo = 1'b0;
    #80;
  endtask : stop
  // Eight bits MSB first, then a ninth bit sent as last and sampled as r
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, r);
  endtask : xfer
endmodule : fcp_master
`default_nettype wire

// ---- verif/fcp_access_tb.sv ----
/*
  Self-checking bench for the access block.
  Assumes the controller model in fcp_master and a pull-up on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fcp_access_tb;
  import fcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] sel = 2'h0;
  logic ev1 = 1'b0, ev2 = 1'b0, powerfail_sense_input = 1'b0, osc = 1'b0;
  logic low = 1'b0, man = 1'b0;
  logic scl, sda, oe, rst_oe, cal, rl, sdo, rlo;
  logic [15:0] adr [3] = '{16'h1fff, 16'h2000, 16'h4000};
  int bad_count = 0;
  int checks = 0;
  always #2 clk = ~clk;
  always #20 osc = ~osc;
  assign rl = !(rst_oe | man);
  fcp_master i_mst (.dev_pull_in(oe), .scl_out(scl), .sda_out(sda));
  fcp_access #(.RST_HOLD(50)) i_dut (.clock_in(clk), .arst_n_in(rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe_out(oe),
    .device_select_pins_in(sel), .event_input_one_in(ev1),
    .event_input_two_in(ev2), .powerfail_sense_input_in(powerfail_sense_input),
    .osc_32k_in(osc), .supply_low_in(low), .reset_line_in(rl),
    .reset_line_out(rlo), .reset_line_oe_out(rst_oe),
    .cal_powerfail_output_out(cal));
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  function automatic logic [7:0] id(input logic [3:0] n, input logic rd);
    return {n, 1'b0, sel, rd};
  endfunction : id
  task automatic send(input logic [7:0] b, input logic ack);
    logic [7:0] q;
    logic r;
    i_mst.xfer(b, 1'b1, q, r);
    chk({7'h0, !r}, {7'h0, ack});
  endtask : send
  task automatic get(input logic last, input logic [7:0] exp);
    logic [7:0] q;
    logic r;
    i_mst.xfer(8'hff, last, q, r);
    chk(q, exp);
  endtask : get
  task automatic mw(input logic [15:0] a);
    i_mst.start();
    send(id(MEM_ID, 1'b0), 1'b1);
    send(a[15:8], 1'b1);
    send(a[7:0], 1'b1);
  endtask : mw
  task automatic creg(input logic [7:0] r, input logic [7:0] v);
    i_mst.start();
    send(id(COMP_ID, 1'b0), 1'b1);
    send(r, 1'b1);
    send(v, 1'b1);
    i_mst.stop();
  endtask : creg
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    bad_count++;
    finish_test();
  end
  initial begin
    logic [7:0] d0, d1;
    int n1, n2;
    realtime t0;
    d0 = 8'($urandom(6));
    d1 = 8'($urandom);
    sel = 2'($urandom);
    n1 = 1 + $urandom % 5;
    n2 = 1 + $urandom % 5;
    tick(5);
    rst_n = 1'b1;
    tick(12);
    for (int s = 0; s < 5; s++) begin
      i_mst.start();
      send({s < 4 ? MEM_ID : 4'h5, 1'b0, 2'(s), 1'b0},
           2'(s) == sel && s < 4);
      i_mst.stop();
    end
    // Last byte then first byte: pointer must wrap
    mw(16'h7fff);
    send(d0, 1'b1);
    send(d1, 1'b1);
    mw(16'h7fff);
    i_mst.start();
    send(id(MEM_ID, 1'b1), 1'b1);
    get(1'b0, d0);
    get(1'b1, d1);
    i_mst.stop();
    mw(16'h7fff);
    send(d0, 1'b1);
    i_mst.stop();
    creg(8'h0c, 8'h01);
    i_mst.start();
    send(id(MEM_ID, 1'b1), 1'b1);
    get(1'b1, d1);
    i_mst.stop();
    // Counter one counts rising, counter two falling edges
    for (int i = 0; i < 5; i++) begin
      ev1 = i < n1;
      ev2 = i < n2;
      tick(12);
      ev1 = 1'b0;
      ev2 = 1'b0;
      tick(12);
    end
    i_mst.start();
    send(id(COMP_ID, 1'b0), 1'b1);
    send(8'h0d, 1'b1);
    i_mst.start();
    send(id(COMP_ID, 1'b1), 1'b1);
    get(1'b0, 8'(n1));
    get(1'b0, 8'h00);
    get(1'b1, 8'(n2));
    i_mst.stop();
    // Cascade: counter one rolls over into counter two
    i_mst.start();
    send(id(COMP_ID, 1'b0), 1'b1);
    send(8'h0c, 1'b1);
    send(8'h05, 1'b1);
    send(8'hff, 1'b1);
    send(8'hff, 1'b1);
    i_mst.stop();
    tick(1);
    ev1 = 1'b1;
    tick(12);
    ev1 = 1'b0;
    tick(12);
    i_mst.start();
    send(id(COMP_ID, 1'b0), 1'b1);
    send(8'h0d, 1'b1);
    i_mst.start();
    send(id(COMP_ID, 1'b1), 1'b1);
    get(1'b0, 8'h00);
    get(1'b0, 8'h00);
    get(1'b1, 8'(n2 + 1));
    i_mst.stop();
    // Each mode against both sides of the quarter and half boundaries
    for (int m = 0; m < 4; m++) begin
      creg(8'h0b, 8'(m << 3));
      for (int k = 0; k < 3; k++) begin
        mw(adr[k]);
        send(8'(m + k), m <= k);
        i_mst.stop();
      end
    end
    for (int k = 0; k < 3; k++) begin
      mw(adr[k]);
      i_mst.start();
      send(id(MEM_ID, 1'b1), 1'b1);
      get(1'b1, 8'(2 * k));
      i_mst.stop();
    end
    for (int i = 0; i < 4; i++) begin
      powerfail_sense_input = 1'($urandom);
      tick(12);
      chk({7'h0, cal}, {7'h0, powerfail_sense_input});
    end
    creg(8'h00, 8'h04);
    @(cal);
    t0 = $realtime;
    @(cal);
    chk(8'(int'(($realtime - t0) / 40.0)), 8'd32);
    creg(8'h00, 8'h00);
    tick(1);
    low = 1'b1;
    tick(8);
    chk({7'h0, rst_oe}, 8'h01);
    i_mst.start();
    send(id(MEM_ID, 1'b0), 1'b0);
    i_mst.stop();
    low = 1'b0;
    tick(90);
    chk({7'h0, rst_oe}, 8'h00);
    man = 1'b1;
    tick(6);
    man = 1'b0;
    tick(4);
    chk({7'h0, rst_oe}, 8'h01);
    chk({6'h0, sdo, rlo}, 8'h00);
    finish_test();
  end
endmodule : fcp_access_tb
`default_nettype wire
